// ---- shared/ossc_pkg.sv ----
// package for the option-select setup control block
package ossc_pkg;
  localparam logic [15:0] OSSC_BOARD_ADDR = 16'h0094;
  localparam logic [15:0] OSSC_ADAPTER_ADDR = 16'h0096;
  localparam logic [15:0] OSSC_POS_LO = 16'h0100;
  localparam logic [15:0] OSSC_POS_HI = 16'h0107;
  localparam logic [7:0] OSSC_BOARD_RST = 8'hFF;
  localparam logic [7:0] OSSC_ADAPTER_RST = 8'h00;
  localparam int OSSC_BIT_BOARD = 7;
  localparam int OSSC_BIT_VIDEO = 5;
  localparam int OSSC_BIT_CHRST = 7;
  localparam int OSSC_BIT_CARD = 3;
  localparam int OSSC_CLK_NS = 8;
  localparam int OSSC_WAIT_CYC_NS = 300;
  localparam int OSSC_REFRESH_NS = 500;
  localparam int OSSC_REFRESH_PERIOD_NS = 15100;
  localparam int OSSC_WAIT_CYC = (OSSC_WAIT_CYC_NS + OSSC_CLK_NS - 1)
                                 / OSSC_CLK_NS;
  localparam int OSSC_REFRESH_CYC = (OSSC_REFRESH_NS + OSSC_CLK_NS - 1)
                                    / OSSC_CLK_NS;
  localparam int OSSC_REFRESH_PERIOD_CYC = OSSC_REFRESH_PERIOD_NS
                                           / OSSC_CLK_NS;
  // wide enough for the longest burst: 38 + (255 + 255) * 15 clocks
  localparam int OSSC_CNT_W = 13;
  typedef enum logic [2:0] {
    OSSC_CYC_RAM, OSSC_CYC_ROM, OSSC_CYC_EXT, OSSC_CYC_MASTER,
    OSSC_CYC_DMA_SINGLE, OSSC_CYC_DMA_BURST
  } ossc_cyc_t;
endpackage

// ---- hdl/ossc_timer.sv ----
// cycle-length timer: holds busy for a loaded number of clocks
module ossc_timer
  import ossc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic [OSSC_CNT_W-1:0] count_i,
  output logic busy_o,
  output logic done_o
);
  logic [OSSC_CNT_W-1:0] cnt_q;
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= count_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= !load_i && (cnt_q == {{(OSSC_CNT_W-1){1'b0}}, 1'b1});
    end
  end
  assign busy_o = (cnt_q != '0);
endmodule

// ---- hdl/ossc_top.sv ----
// option-select setup strobes, enable/setup registers and cycle timing
// Behaviour
// - pos window answered only under own strobe
// - board bit5 low strobes video setup
// - adapter bit3 high strobes adapter setup
// - board bit7 low strobes board setup
// - setup registers take 8-bit transfers only
// - processor RAM access one wait, 300ns
// - processor ROM access one wait, 300ns
// - extended channel cycle one wait, 300ns
// - refresh at least 500ns, every 15.1us
// - bus master RAM cycle at least 300ns
// - single DMA is 300ns plus accesses
// - burst DMA is 300ns plus N accesses
// - registers read/write, board resets to FF
module ossc_top
  import ossc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic io_wide_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  output logic video_setup_o,
  output logic board_setup_o,
  output logic adapter_setup_o,
  output logic [2:0] adapter_sel_o,
  output logic channel_reset_o,
  output logic video_pos_en_o,
  output logic board_pos_en_o,
  output logic adapter_pos_en_o,
  output logic setup_conflict_o,
  input wire logic cyc_start_i,
  input wire ossc_cyc_t cyc_kind_i,
  input wire logic [7:0] dma_io_cyc_i,
  input wire logic [7:0] dma_mem_cyc_i,
  input wire logic [3:0] dma_count_i,
  output logic cyc_busy_o,
  output logic cyc_ready_o,
  output logic refresh_req_o
);
  logic [7:0] board_q;
  logic [7:0] adapter_q;
  logic sel_board;
  logic sel_adapter;
  logic in_pos;
  logic [OSSC_CNT_W-1:0] load_cnt;
  logic tmr_busy;
  logic tmr_done;
  logic [OSSC_CNT_W-1:0] refresh_q;
  logic [OSSC_CNT_W-1:0] refresh_len_q;

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // 16-bit accesses are simply ignored so they cannot half-write a register
  assign sel_board = (io_addr_i == OSSC_BOARD_ADDR) && !io_wide_i;
  assign sel_adapter = (io_addr_i == OSSC_ADAPTER_ADDR) && !io_wide_i;
  assign in_pos = in_range(io_addr_i, OSSC_POS_LO, OSSC_POS_HI);

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      board_q <= OSSC_BOARD_RST;
    end else if (io_wr_i && sel_board) begin
      board_q <= io_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      adapter_q <= OSSC_ADAPTER_RST;
    end else if (io_wr_i && sel_adapter) begin
      adapter_q <= io_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      io_rdata_o <= 8'h00;
      io_rvalid_o <= 1'b0;
    end else begin
      io_rvalid_o <= io_rd_i && (sel_board || sel_adapter);
      if (io_rd_i && sel_board) begin
        io_rdata_o <= board_q;
      end else if (io_rd_i && sel_adapter) begin
        io_rdata_o <= adapter_q;
      end else begin
        io_rdata_o <= 8'h00;
      end
    end
  end

  // strobes follow the stored bits; a write shows on the next clock
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      video_setup_o <= 1'b0;
      board_setup_o <= 1'b0;
      adapter_setup_o <= 1'b0;
      adapter_sel_o <= 3'h0;
      channel_reset_o <= 1'b0;
      setup_conflict_o <= 1'b0;
    end else begin
      video_setup_o <= !board_q[OSSC_BIT_VIDEO];
      board_setup_o <= !board_q[OSSC_BIT_BOARD];
      adapter_setup_o <= adapter_q[OSSC_BIT_CARD];
      adapter_sel_o <= adapter_q[2:0];
      channel_reset_o <= adapter_q[OSSC_BIT_CHRST];
      // flags a software misstep; hardware cannot refuse the write
      setup_conflict_o <= adapter_q[OSSC_BIT_CARD] &&
        (!board_q[OSSC_BIT_VIDEO] || !board_q[OSSC_BIT_BOARD]);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      video_pos_en_o <= 1'b0;
      board_pos_en_o <= 1'b0;
      adapter_pos_en_o <= 1'b0;
    end else begin
      video_pos_en_o <= in_pos && !board_q[OSSC_BIT_VIDEO];
      board_pos_en_o <= in_pos && !board_q[OSSC_BIT_BOARD];
      adapter_pos_en_o <= in_pos && adapter_q[OSSC_BIT_CARD];
    end
  end

  always_comb begin
    load_cnt = OSSC_CNT_W'(OSSC_WAIT_CYC);
    case (cyc_kind_i)
      OSSC_CYC_RAM: load_cnt = OSSC_CNT_W'(OSSC_WAIT_CYC);
      OSSC_CYC_ROM: load_cnt = OSSC_CNT_W'(OSSC_WAIT_CYC);
      OSSC_CYC_EXT: load_cnt = OSSC_CNT_W'(OSSC_WAIT_CYC);
      OSSC_CYC_MASTER: load_cnt = OSSC_CNT_W'(OSSC_WAIT_CYC);
      OSSC_CYC_DMA_SINGLE: load_cnt = OSSC_CNT_W'(OSSC_WAIT_CYC)
        + OSSC_CNT_W'(dma_io_cyc_i) + OSSC_CNT_W'(dma_mem_cyc_i);
      OSSC_CYC_DMA_BURST: load_cnt = OSSC_CNT_W'(OSSC_WAIT_CYC)
        + OSSC_CNT_W'((9'(dma_io_cyc_i) + 9'(dma_mem_cyc_i))
                      * 13'(dma_count_i));
      default: load_cnt = OSSC_CNT_W'(OSSC_WAIT_CYC);
    endcase
  end

  ossc_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .load_i(cyc_start_i && !tmr_busy),
    .count_i(load_cnt),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cyc_busy_o <= 1'b0;
      cyc_ready_o <= 1'b0;
    end else begin
      cyc_busy_o <= tmr_busy || (cyc_start_i && !tmr_busy);
      cyc_ready_o <= tmr_done;
    end
  end

  // refresh period counter, then hold request for the least refresh length
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      refresh_q <= '0;
    end else if (refresh_q == OSSC_CNT_W'(OSSC_REFRESH_PERIOD_CYC - 1)) begin
      refresh_q <= '0;
    end else begin
      refresh_q <= refresh_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      refresh_len_q <= '0;
      refresh_req_o <= 1'b0;
    end else begin
      if (refresh_q == OSSC_CNT_W'(OSSC_REFRESH_PERIOD_CYC - 1)) begin
        refresh_len_q <= OSSC_CNT_W'(OSSC_REFRESH_CYC);
      end else if (refresh_len_q != '0) begin
        refresh_len_q <= refresh_len_q - 1'b1;
      end
      refresh_req_o <= (refresh_q == OSSC_CNT_W'(OSSC_REFRESH_PERIOD_CYC - 1))
                       || (refresh_len_q > OSSC_CNT_W'(1));
    end
  end

  a_video_strobe: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    io_wr_i && sel_board && !io_wdata_i[OSSC_BIT_VIDEO] |=> ##1 video_setup_o)
    else $error("video strobe missing");
  a_board_strobe: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    io_wr_i && sel_board |=> ##1 board_setup_o == !$past(io_wdata_i[7], 2))
    else $error("board strobe wrong");
  a_adapter_strobe: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    io_wr_i && sel_adapter |=> ##1 adapter_setup_o == $past(io_wdata_i[3], 2))
    else $error("adapter strobe wrong");
  a_pos_gate: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    adapter_pos_en_o |-> $past(in_pos) && adapter_setup_o)
    else $error("pos window open without strobe");
  a_reg_readback: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    io_wr_i && sel_adapter ##1 io_rd_i && sel_adapter && !io_wr_i
    |=> io_rdata_o == $past(io_wdata_i, 2))
    else $error("readback mismatch");
  a_wide_ignored: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    io_wr_i && io_wide_i |=> $stable(board_q) && $stable(adapter_q))
    else $error("wide write changed register");
  a_ram_length: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    cyc_start_i && !tmr_busy && cyc_kind_i == OSSC_CYC_RAM
    |-> ##39 !cyc_ready_o ##1 cyc_ready_o)
    else $error("ram cycle length wrong");
  a_refresh_len: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(refresh_req_o) |-> refresh_req_o [*8])
    else $error("refresh too short");

  // counts the whole pulse; a short repetition cannot see it cut early
  logic [OSSC_CNT_W-1:0] refresh_run_q;
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      refresh_run_q <= '0;
    end else if (refresh_req_o) begin
      refresh_run_q <= refresh_run_q + 1'b1;
    end else begin
      refresh_run_q <= '0;
    end
  end
  a_refresh_min: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $fell(refresh_req_o) |-> refresh_run_q >= OSSC_CNT_W'(OSSC_REFRESH_CYC))
    else $error("refresh shorter than minimum");
  a_reset_ff: assert property (@(posedge sys_clk_i)
    !nrst_i |=> board_q == OSSC_BOARD_RST)
    else $error("board reset value wrong");
  c_adapter_setup: cover property (@(posedge sys_clk_i) adapter_setup_o);
  c_video_setup: cover property (@(posedge sys_clk_i) video_setup_o);
  c_dma_burst: cover property (@(posedge sys_clk_i)
    cyc_start_i && cyc_kind_i == OSSC_CYC_DMA_BURST);
endmodule

// ---- dv/ossc_adapter_model.sv ----
// adapter card model sitting behind the adapter setup strobe
module ossc_adapter_model
  #(parameter logic [2:0] SLOT = 3'h3)
(
  input wire logic sys_clk_i,
  input wire logic setup_i,
  input wire logic [2:0] sel_i,
  input wire logic pos_en_i,
  input wire logic chan_reset_i,
  output logic answer_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a card held in channel reset stays silent even when strobed
  always_ff @(posedge sys_clk_i) begin
    answer_o <= pos_en_i & setup_i & (sel_i == SLOT)
                & ~chan_reset_i;
  end
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the option-select setup control block
module tb
  import ossc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, wr_en = 0, rd_en = 0, wide = 0, st = 0;
  logic [15:0] a = 16'h0000;
  logic [7:0] wd = 8'h00, io = 8'h02, mem = 8'h03, rdat;
  logic [3:0] cnt = 4'h2;
  ossc_cyc_t kind = OSSC_CYC_RAM;
  logic rvalid, vs, bs, as, chr, vpe, bpe, ape, conf, busy, rdy, refr, hit;
  logic [2:0] sel;
  int mismatches = 0, samples_checked = 0;
  always #4 clk = ~clk;
  ossc_top u_ossc_top (.sys_clk_i(clk), .nrst_i(nrst), .io_wr_i(wr_en),
    .io_rd_i(rd_en), .io_wide_i(wide), .io_addr_i(a), .io_wdata_i(wd),
    .io_rdata_o(rdat), .io_rvalid_o(rvalid), .video_setup_o(vs),
    .board_setup_o(bs), .adapter_setup_o(as), .adapter_sel_o(sel),
    .channel_reset_o(chr), .video_pos_en_o(vpe), .board_pos_en_o(bpe),
    .adapter_pos_en_o(ape), .setup_conflict_o(conf), .cyc_start_i(st),
    .cyc_kind_i(kind), .dma_io_cyc_i(io), .dma_mem_cyc_i(mem),
    .dma_count_i(cnt), .cyc_busy_o(busy), .cyc_ready_o(rdy),
    .refresh_req_o(refr));
  ossc_adapter_model u_ossc_adapter_model (.sys_clk_i(clk), .setup_i(as),
    .sel_i(sel), .pos_en_i(ape), .chan_reset_i(chr), .answer_o(hit));
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // strobes settle one edge after the write edge, so wait three
  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    tick();
    wr_en = 1;
    a = ad;
    wd = d;
    tick();
    wr_en = 0;
    wide = 0;
    repeat (3) tick();
  endtask
  task automatic rd(input string n, input logic [15:0] ad, logic [7:0] e);
    int k;
    tick();
    rd_en = 1;
    a = ad;
    tick();
    rd_en = 0;
    for (k = 0; k < 3 && rvalid !== 1'b1; k++) tick();
    chk(n, e, rdat);
  endtask
  task automatic pos(input logic [15:0] ad, input logic [2:0] e);
    a = ad;
    repeat (3) tick();
    chk("pos enables", e, {vpe, bpe, ape});
  endtask
  task automatic cyc(input ossc_cyc_t kd, input int e);
    int n;
    tick();
    st = 1;
    kind = kd;
    tick();
    st = 0;
    chk("cycle busy", 1'b1, busy);
    for (n = 0; n < 200 && rdy !== 1'b1; n++) tick();
    chk("cycle length", 16'(e), 16'(n));
    chk("cycle idle", 1'b0, busy);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    complete_run();
  end
  initial begin
    int n;
    repeat (8) tick();
    nrst = 1;
    rd("board reg", OSSC_BOARD_ADDR, OSSC_BOARD_RST);
    rd("adapter reg", OSSC_ADAPTER_ADDR, OSSC_ADAPTER_RST);
    chk("strobes", 3'b000, {vs, bs, as});
    wr(OSSC_ADAPTER_ADDR, 8'h00);
    wr(OSSC_BOARD_ADDR, 8'hD5);
    chk("strobes", 3'b100, {vs, bs, as});
    rd("board reg", OSSC_BOARD_ADDR, 8'hD5);
    pos(16'h0102, 3'b100);
    pos(16'h0108, 3'b000);
    wr(OSSC_BOARD_ADDR, 8'h7F);
    chk("strobes", 3'b010, {vs, bs, as});
    pos(16'h0107, 3'b010);
    nrst = 0;
    repeat (2) tick();
    nrst = 1;
    rd("board reg", OSSC_BOARD_ADDR, OSSC_BOARD_RST);
    chk("strobes", 3'b000, {vs, bs, as});
    wr(OSSC_BOARD_ADDR, 8'hFF);
    wr(OSSC_ADAPTER_ADDR, 8'h0B);
    chk("strobes", 3'b001, {vs, bs, as});
    chk("adapter sel", 3'h3, sel);
    chk("channel reset", 1'b0, chr);
    chk("conflict", 1'b0, conf);
    pos(16'h0100, 3'b001);
    chk("card answer", 1'b1, hit);
    wide = 1;
    wr(OSSC_ADAPTER_ADDR, 8'h00);
    rd("adapter reg", OSSC_ADAPTER_ADDR, 8'h0B);
    wr(OSSC_ADAPTER_ADDR, 8'h03);
    chk("strobes", 3'b000, {vs, bs, as});
    pos(16'h0100, 3'b000);
    chk("card answer", 1'b0, hit);
    cyc(OSSC_CYC_RAM, OSSC_WAIT_CYC + 1);
    cyc(OSSC_CYC_ROM, OSSC_WAIT_CYC + 1);
    cyc(OSSC_CYC_EXT, OSSC_WAIT_CYC + 1);
    cyc(OSSC_CYC_MASTER, OSSC_WAIT_CYC + 1);
    cyc(OSSC_CYC_DMA_SINGLE, OSSC_WAIT_CYC + io + mem + 1);
    cyc(OSSC_CYC_DMA_BURST, OSSC_WAIT_CYC + (io + mem) * cnt + 1);
    for (n = 0; n < 2000 && refr !== 1'b1; n++) tick();
    for (n = 0; n < 200 && refr === 1'b1; n++) tick();
    chk("refresh long", 1'b1, 16'(n >= OSSC_REFRESH_CYC));
    for (n = 0; n < 2000 && refr !== 1'b1; n++) tick();
    n = n + OSSC_REFRESH_CYC;
    chk("refresh period", 16'(OSSC_REFRESH_PERIOD_CYC), 16'(n));
    // write then read in the very next cycle
    tick();
    wr_en = 1;
    a = OSSC_ADAPTER_ADDR;
    wd = 8'h05;
    tick();
    wr_en = 0;
    rd_en = 1;
    tick();
    rd_en = 0;
    chk("read valid", 1'b1, rvalid);
    chk("adapter back to back", 8'h05, rdat);
    wr(OSSC_ADAPTER_ADDR, 8'h80);
    chk("channel reset", 1'b1, chr);
    wr(OSSC_ADAPTER_ADDR, 8'h00);
    wr(OSSC_BOARD_ADDR, 8'hFF);
    chk("strobes", 3'b000, {vs, bs, as});
    chk("channel reset", 1'b0, chr);
    chk("conflict", 1'b0, conf);
    complete_run();
  end
endmodule
